// >>> core/svcg_top.sv
`timescale 1ns/1ns
module svcg_top
  import svcg_pkg::*;
#(
  parameter int ACC_W = ACC_W_DEF
)(
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  input  wire logic              CLK_EN,
  input  wire logic              PERIOD_START,
  input  wire logic [ACC_W-1:0]  PHASE_STEP,
  input  wire logic [DATA_W-1:0] MOD_INDEX,
  input  wire logic [DATA_W-1:0] PWM_PERIOD,
  input  wire logic              SYMMETRIC,
  output svcg_cmp_t              COMPARE,
  output logic                   COMPARE_VALID,
  output logic      [2:0]        SECTOR,
  output logic                   BUSY
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  svcg_state_t        state;
  svcg_state_t        next_state;
  logic [ACC_W-1:0]   acc;
  logic [ACC_W:0]     next_acc;
  logic [2:0]         sector;
  logic [PTR_W-1:0]   ptr;
  logic [PTR_W-1:0]   rom_addr;
  logic [DATA_W-1:0]  rom_data;
  logic               start_ok;
  logic               ptr_zero;
  logic [DATA_W-1:0]  period_q;
  logic [DATA_W-1:0]  mod_q;
  logic               sym_q;
  logic [DATA_W-1:0]  sin_y;
  logic [DATA_W-1:0]  sin_x;
  logic [DATA_W-1:0]  first_vector_duty;
  logic [DATA_W-1:0]  second_vector_duty;
  logic [DATA_W-1:0]  first_duty_cnt;
  logic [DATA_W-1:0]  second_duty_cnt;
  logic [DATA_W:0]    zero_raw;
  logic [DATA_W-1:0]  zero_vector_duty;
  logic [DATA_W-1:0]  base_compare_time;
  logic [2*DATA_W-1:0] prod_x;
  logic [2*DATA_W-1:0] prod_y;
  svcg_cmp_t          next_cmp;
  svcg_cmp_t          edge_cmp;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  // A period start is taken only while idle; the sequence is short
  // against any real PWM period, so a start during it is dropped
  assign start_ok = PERIOD_START && (state == ST_IDLE);
  assign next_acc = {1'b0, acc} + {1'b0, PHASE_STEP};
  assign ptr      = acc[ACC_W-1 -: PTR_W];
  assign BUSY     = (state != ST_IDLE);
  assign SECTOR   = sector;

  // ---------------------------------------------------------------
  // Phase accumulator and sector counter
  // ---------------------------------------------------------------
  // Output frequency follows step * fs / (6 * 2^ACC_W): one step of
  // a 16 bit accumulator at 24 kHz moves the vector by 0.061 Hz
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      acc <= '0;
    end else if (CLK_EN && start_ok) begin
      acc <= next_acc[ACC_W-1:0];
    end
  end

  acc_step_a: assert property (
    CLK_EN && start_ok |=>
      acc == ACC_W'($past(acc) + $past(PHASE_STEP)))
    else $error("accumulator did not add the step");

  // Carry out of the accumulator means the pointer wrapped the table
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sector <= SECTOR_RST;
    end else if (CLK_EN && start_ok && next_acc[ACC_W]) begin
      if (sector == SECTOR_LAST) begin
        sector <= SECTOR_RST;
      end else begin
        sector <= sector + 3'h1;
      end
    end
  end

  sector_range_a: assert property (
    sector <= SECTOR_LAST)
    else $error("sector counter left 0..5");

  sector_wrap_a: assert property (
    CLK_EN && start_ok && next_acc[ACC_W] |=>
      sector == (($past(sector) == SECTOR_LAST) ? SECTOR_RST
                 : 3'($past(sector) + 3'h1)))
    else $error("sector did not advance on pointer wrap");

  sector_hold_a: assert property (
    !(CLK_EN && start_ok && next_acc[ACC_W]) |=> $stable(sector))
    else $error("sector moved without a wrap");

  // Snapshot of the operands so a mid-sequence change cannot mix
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      period_q <= '0;
      mod_q    <= '0;
      sym_q    <= 1'b0;
    end else if (CLK_EN && start_ok) begin
      period_q <= PWM_PERIOD;
      mod_q    <= MOD_INDEX;
      sym_q    <= SYMMETRIC;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:    if (PERIOD_START) next_state = ST_FETCH_Y;
      ST_FETCH_Y: next_state = ST_FETCH_X;
      ST_FETCH_X: next_state = ST_CAP_X;
      ST_CAP_X:   next_state = ST_DUTY;
      ST_DUTY:    next_state = ST_SCALE;
      ST_SCALE:   next_state = ST_MAP;
      ST_MAP:     next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Sine table access
  // ---------------------------------------------------------------
  // sin(angle) reads entry ptr; sin(60 - angle) reads entry 256 - ptr,
  // which falls off the table at ptr 0 and is then sin(60) itself
  assign ptr_zero = (ptr == '0);

  always_comb begin
    rom_addr = ptr;
    if (state == ST_FETCH_X) begin
      rom_addr = PTR_W'(0) - ptr;
    end
  end

  rom_addr_a: assert property (
    state == ST_FETCH_Y |-> rom_addr == acc[ACC_W-1 -: PTR_W])
    else $error("table address is not the pointer");

  svcg_sine_rom u_rom (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .en   (CLK_EN),
    .addr (rom_addr),
    .data (rom_data)
  );

  // Capture both sines one cycle after their address
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sin_y <= '0;
      sin_x <= '0;
    end else if (CLK_EN) begin
      if (state == ST_FETCH_X) begin
        sin_y <= rom_data;
      end
      if (state == ST_CAP_X) begin
        sin_x <= ptr_zero ? SIN60_Q15 : rom_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Duty ratios and scaling to timer counts
  // ---------------------------------------------------------------
  // One shared pair of multipliers serves both steps, trading a
  // cycle of latency for half the multiplier area
  always_comb begin
    prod_x = mod_q * sin_x;
    prod_y = mod_q * sin_y;
    if (state == ST_SCALE) begin
      prod_x = first_vector_duty * period_q;
      prod_y = second_vector_duty * period_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      first_vector_duty  <= '0;
      second_vector_duty <= '0;
    end else if (CLK_EN && state == ST_DUTY) begin
      first_vector_duty  <= prod_x[Q_SHIFT +: DATA_W];
      second_vector_duty <= prod_y[Q_SHIFT +: DATA_W];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      first_duty_cnt  <= '0;
      second_duty_cnt <= '0;
    end else if (CLK_EN && state == ST_SCALE) begin
      first_duty_cnt  <= prod_x[Q_SHIFT +: DATA_W];
      second_duty_cnt <= prod_y[Q_SHIFT +: DATA_W];
    end
  end

  // Zero duty takes what the active vectors leave of the period;
  // rounding can only push it below zero by a count, so clamp there
  assign zero_raw = {1'b0, period_q} - {1'b0, first_duty_cnt}
                  - {1'b0, second_duty_cnt};
  assign zero_vector_duty  = zero_raw[DATA_W] ? '0
                           : zero_raw[DATA_W-1:0];
  assign base_compare_time = {1'b0, zero_vector_duty[DATA_W-1:1]};

  duty_fill_a: assert property (
    state == ST_MAP && !zero_raw[DATA_W] |->
      17'(zero_vector_duty + first_duty_cnt + second_duty_cnt)
      == {1'b0, period_q})
    else $error("duties do not fill the period");

  // ---------------------------------------------------------------
  // Sector mapping to compare times
  // ---------------------------------------------------------------
  always_comb begin
    edge_cmp = '{default: '0};
    case (sector)
      3'h0: begin
        edge_cmp.phase_a = base_compare_time;
        edge_cmp.phase_b = first_duty_cnt + edge_cmp.phase_a;
        edge_cmp.phase_c = period_q - edge_cmp.phase_a;
      end
      3'h1: begin
        edge_cmp.phase_b = base_compare_time;
        edge_cmp.phase_a = second_duty_cnt + edge_cmp.phase_b;
        edge_cmp.phase_c = period_q - edge_cmp.phase_b;
      end
      3'h2: begin
        edge_cmp.phase_b = base_compare_time;
        edge_cmp.phase_c = first_duty_cnt + edge_cmp.phase_b;
        edge_cmp.phase_a = period_q - edge_cmp.phase_b;
      end
      3'h3: begin
        edge_cmp.phase_c = base_compare_time;
        edge_cmp.phase_b = second_duty_cnt + edge_cmp.phase_c;
        edge_cmp.phase_a = period_q - edge_cmp.phase_c;
      end
      3'h4: begin
        edge_cmp.phase_c = base_compare_time;
        edge_cmp.phase_a = first_duty_cnt + edge_cmp.phase_c;
        edge_cmp.phase_b = period_q - edge_cmp.phase_c;
      end
      3'h5: begin
        edge_cmp.phase_a = base_compare_time;
        edge_cmp.phase_c = second_duty_cnt + edge_cmp.phase_a;
        edge_cmp.phase_b = period_q - edge_cmp.phase_a;
      end
      default: begin
        edge_cmp = '{default: '0};
      end
    endcase
  end

  // Centre-aligned timers count up and down over the period, so each
  // compare is halved; only the final scaling differs between modes
  always_comb begin
    next_cmp = edge_cmp;
    if (sym_q) begin
      next_cmp.phase_a = {1'b0, edge_cmp.phase_a[DATA_W-1:1]};
      next_cmp.phase_b = {1'b0, edge_cmp.phase_b[DATA_W-1:1]};
      next_cmp.phase_c = {1'b0, edge_cmp.phase_c[DATA_W-1:1]};
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the compare units
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      COMPARE <= '{default: CMP_RST};
    end else if (CLK_EN && state == ST_MAP) begin
      COMPARE <= next_cmp;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      COMPARE_VALID <= 1'b0;
    end else if (CLK_EN) begin
      COMPARE_VALID <= (state == ST_MAP);
    end
  end

  latency_a: assert property (
    CLK_EN && start_ok ##1 CLK_EN [*6] |=> COMPARE_VALID)
    else $error("compare set not delivered on time");

  valid_pulse_a: assert property (
    COMPARE_VALID && CLK_EN |=> !COMPARE_VALID)
    else $error("valid held past one enabled cycle");

  sector0_map_a: assert property (
    CLK_EN && state == ST_MAP && sector == 3'h0 && !sym_q |=>
      COMPARE.phase_c == 16'($past(period_q) - COMPARE.phase_a)
      && COMPARE.phase_b == 16'($past(first_duty_cnt) + COMPARE.phase_a))
    else $error("sector 0 compare mapping wrong");

  sector3_map_a: assert property (
    CLK_EN && state == ST_MAP && sector == 3'h3 && !sym_q |=>
      COMPARE.phase_a == 16'($past(period_q) - COMPARE.phase_c)
      && COMPARE.phase_b == 16'($past(second_duty_cnt) + COMPARE.phase_c))
    else $error("sector 3 compare mapping wrong");

endmodule

// >>> common/svcg_pkg.sv
package svcg_pkg;

  // ---------------------------------------------------------------
  // Sizes and fixed-point formats
  // ---------------------------------------------------------------
  localparam int ACC_W_DEF   = 16;   // Phase accumulator width
  localparam int PTR_W       = 8;    // Table pointer width
  localparam int TABLE_DEPTH = 256;  // Words in the 60 degree table
  localparam int DATA_W      = 16;   // Compare and Q15 data width
  localparam int Q_SHIFT     = 15;   // Q15 product renormalisation

  // ---------------------------------------------------------------
  // Reset values and fixed figures
  // ---------------------------------------------------------------
  localparam logic [2:0]  SECTOR_RST  = 3'h0;
  localparam logic [2:0]  SECTOR_LAST = 3'h5;   // Six sectors, 0..5
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [15:0] SIN60_Q15   = 16'h6eda; // sin(60) in Q15
  localparam int          LATENCY     = 6;      // Enabled edges to valid

  // Table generation: angle of entry i is i * pi / (3 * 256)
  localparam longint PI_Q30    = 64'sh00000000c90fdaa2;
  localparam longint ANGLE_DIV = 64'sh0000000000000300;
  localparam longint HALF_LSB  = 64'sh0000000000004000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FETCH_Y = 3'b001,
    ST_FETCH_X = 3'b010,
    ST_CAP_X   = 3'b011,
    ST_DUTY    = 3'b100,
    ST_SCALE   = 3'b101,
    ST_MAP     = 3'b110
  } svcg_state_t;

  typedef struct packed {
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
  } svcg_cmp_t;

  // Q15 sine of table entry idx, evaluated at elaboration by a
  // fixed-point Taylor series in Q30 so no real arithmetic is needed
  function automatic logic [15:0] svcg_sine_q15(input int idx);
    longint x;
    longint x2;
    longint term;
    longint s;
    x = (longint'(idx) * PI_Q30) / ANGLE_DIV;
    x2 = (x * x) >>> 30;
    term = x;
    s = x;
    for (int k = 1; k < 6; k++) begin
      term = -((term * x2) >>> 30) / longint'((2 * k) * (2 * k + 1));
      s = s + term;
    end
    return 16'((s + HALF_LSB) >>> Q_SHIFT);
  endfunction

endpackage

// >>> core/svcg_sine_rom.sv
`timescale 1ns/1ns
module svcg_sine_rom
  import svcg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              en,
  input  wire logic [PTR_W-1:0]  addr,
  output logic      [DATA_W-1:0] data
);

  logic [DATA_W-1:0] table_mem [TABLE_DEPTH];

  // ---------------------------------------------------------------
  // Table contents: Q15 sine over 0..60 degrees, 0.23 degree steps
  // ---------------------------------------------------------------
  for (genvar g = 0; g < TABLE_DEPTH; g++) begin : g_fill
    assign table_mem[g] = svcg_sine_q15(g);
  end

  // Registered read keeps the table a plain synchronous ROM
  always_ff @(posedge clk) begin
    if (rst) begin
      data <= CMP_RST;
    end else if (en) begin
      data <= table_mem[addr];
    end
  end

endmodule

// >>> tb/svcg_timer_model.sv
`timescale 1ns/1ns
module svcg_timer_model
  import svcg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] interval,
  input  wire svcg_cmp_t  cmp,
  input  wire logic       cmp_valid,
  output logic            start,
  output logic      [2:0] pwm
);
  // ------------------------------------------------------------
  // Period timer standing in for the compare units
  // ------------------------------------------------------------
  logic [7:0] cnt;
  svcg_cmp_t  shadow;

  // Short gaps force starts into a busy block, long ones leave it idle
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt   <= 8'h00;
      start <= 1'b0;
    end else begin
      start <= (cnt >= interval - 8'h01);
      cnt   <= (cnt >= interval - 8'h01) ? 8'h00 : cnt + 8'h01;
    end
  end

  // Shadow load on delivery, so a set is never split across phases
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow <= '0;
    end else if (cmp_valid) begin
      shadow <= cmp;
    end
  end

  // Edge-aligned outputs: high while the count is below the compare
  assign pwm[2] = {8'h00, cnt} < shadow.phase_a;
  assign pwm[1] = {8'h00, cnt} < shadow.phase_b;
  assign pwm[0] = {8'h00, cnt} < shadow.phase_c;
endmodule

// >>> tb/svcg_top_tb_top.sv
`timescale 1ns/1ns
module svcg_top_tb_top
  import svcg_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and expectation queue
  // ------------------------------------------------------------
  typedef struct {
    svcg_cmp_t  c;
    logic [2:0] s;
    int         t;
  } svcg_note_t;

  logic        mclk, sys_rst, clk_en, run, sym, start, valid, busy;
  logic [15:0] step, mod, per, acc;
  logic [7:0]  gap;
  logic [2:0]  sec, sector;
  svcg_cmp_t   cmp;
  svcg_note_t  q[$];
  svcg_note_t  n, r;
  int          sine[256];
  int          bad_count, n_tests, n_del, cyc;

  svcg_top #(.ACC_W(16)) DUT (
    .MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .PERIOD_START(start), .PHASE_STEP(step), .MOD_INDEX(mod),
    .PWM_PERIOD(per), .SYMMETRIC(sym), .COMPARE(cmp),
    .COMPARE_VALID(valid), .SECTOR(sector), .BUSY(busy));
  svcg_timer_model u_tmr (
    .clk(mclk), .rst(sys_rst), .run(run), .interval(gap),
    .cmp(cmp), .cmp_valid(valid), .start(start), .pwm());

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  // ------------------------------------------------------------
  // Reference arithmetic
  // ------------------------------------------------------------
  // Compare set for one period; sums wrap at 16 bits like the timer
  function automatic svcg_cmp_t ref_cmp(int p, int m, int t, int s,
                                        bit h);
    int sx, sy, fd, sd, z, b;
    int v[3];
    int bi[6] = '{0, 1, 1, 2, 2, 0};
    int pi[6] = '{1, 0, 2, 1, 0, 2};
    int mi[6] = '{2, 2, 0, 0, 1, 1};
    sy = sine[p];
    sx = (p == 0) ? int'(SIN60_Q15) : sine[256 - p];
    fd = (((m * sx) >>> 15) * t) >>> 15;
    sd = (((m * sy) >>> 15) * t) >>> 15;
    z = t - fd - sd;
    b = (z < 0) ? 0 : z >>> 1;
    v[bi[s]] = b;
    v[pi[s]] = ((s % 2) ? sd : fd) + b;
    v[mi[s]] = t - b;
    for (int k = 0; k < 3; k++)
      v[k] = (v[k] & 32'h0000ffff) >>> h;
    return svcg_cmp_t'({v[0][15:0], v[1][15:0], v[2][15:0]});
  endfunction

  task automatic report(logic [47:0] e, logic [47:0] g);
    bad_count++;
    $display("wrong value at %0t: expected %h got %h", $time, e, g);
  endtask

  task automatic check_cmp(svcg_cmp_t e, svcg_cmp_t g);
    n_tests++;
    if (g !== e) report(e, g);
  endtask

  task automatic check_num(logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) report(48'(e), 48'(g));
  endtask

  task automatic idle_check();
    check_cmp('0, cmp);
    check_num(16'h0000, 16'(sector));
    check_num(16'h0000, {14'h0000, valid, busy});
  endtask

  // Wait for k more deliveries under a bound; returns just off the edge
  task automatic wait_del(int k);
    int lim;
    lim = n_del + k;
    for (int w = 0; w < 4000 && n_del < lim; w++) @(posedge mclk);
    if (n_del < lim) report(48'(lim), 48'(n_del));
    #1;
  endtask

  // b=0: wait until neither busy nor delivering; b=1: until busy
  task automatic wait_state(bit b);
    for (int w = 0; w < 100 && ((busy | (valid & ~b)) != b); w++) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Driver side notes: accumulator, sector and result per start
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sys_rst) begin
      acc = 16'h0000;
      sec = 3'h0;
      q.delete();
    end else if (clk_en && start && !busy) begin
      if (17'(acc) + 17'(step) > 17'h0ffff)
        sec = (sec == 3'h5) ? 3'h0 : sec + 3'h1;
      acc = acc + step;
      n.c = ref_cmp(int'(acc[15:8]), int'(mod), int'(per), int'(sec), sym);
      n.s = sec;
      n.t = cyc;
      q.push_back(n);
    end
  end

  // Monitor: each delivery is matched against the oldest note
  always @(posedge mclk) begin
    if (!sys_rst && clk_en && valid) begin
      n_del <= n_del + 1;
      if (q.size() == 0) begin
        report(48'h0, 48'h1);
      end else begin
        r = q.pop_front();
        check_cmp(r.c, cmp);
        check_num(16'(r.s), 16'(sector));
        check_num(16'(r.t + LATENCY + 1), 16'(cyc));
      end
    end
  end

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    summarize();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 0;
    sys_rst = 1;
    clk_en = 1;
    run = 0;
    gap = 8'h07;
    step = 16'h0400;
    mod = 16'h7fff;
    per = 16'h1000;
    sym = 0;
    cyc = 0;
    bad_count = 0;
    n_tests = 0;
    n_del = 0;
    for (int i = 0; i < 256; i++)
      sine[i] = int'(32768.0 * $sin(i * 3.14159265358979 / 768.0));
    void'($urandom(6));
    repeat (4) @(posedge mclk);
    #1 sys_rst = 0;
    idle_check();
    // Back-to-back periods over one whole revolution, all six sectors
    run = 1;
    wait_del(384);
    // Full-scale period, zero index edge-aligned then full index centre-aligned
    mod = 16'h0000;
    per = 16'hffff;
    wait_del(2);
    mod = 16'h7fff;
    sym = 1;
    wait_del(2);
    // Starts offered while disabled must not step the accumulator
    gap = 8'h14;
    wait_state(0);
    clk_en = 0;
    gap = 8'h03;
    repeat (40) @(posedge mclk);
    #1 clk_en = 1;
    wait_del(5);
    // Random operands; gaps of 3 to 14, the short ones offer starts during busy
    for (int i = 0; i < 150; i++) begin
      step = 16'($urandom);
      mod = 16'($urandom) & 16'h7fff;
      per = 16'($urandom);
      sym = 1'($urandom);
      gap = 8'(3 + $urandom % 12);
      wait_del(1);
    end
    // Reset in mid-sequence clears outputs and the accumulator
    wait_state(1);
    sys_rst = 1;
    run = 0;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 0;
    idle_check();
    run = 1;
    wait_del(3);
    run = 0;
    wait_state(0);
    repeat (10) @(posedge mclk);
    check_num(16'h0000, 16'(q.size()));
    summarize();
  end
endmodule
